/* File: hw/aspc_defs.svh */
`ifndef ASPC_DEFS_SVH
`define ASPC_DEFS_SVH
// Clock and conversion timing
`define ASPC_CLK_HZ 200000000
`define ASPC_DATA_RATE_HZ 814
`define ASPC_CONV_CYCLES (`ASPC_CLK_HZ / `ASPC_DATA_RATE_HZ)
`define ASPC_XIN_DIV 8
`define ASPC_GUARD_XIN 12
`define ASPC_SLAVE_SCLK_RATIO 5
`define ASPC_TURN_XIN 3
`define ASPC_HOST_GAP_XIN 6
// Instruction byte fields
`define ASPC_INS_READ_BIT 7
`define ASPC_INS_NB_MSB 6
`define ASPC_INS_NB_LSB 5
`define ASPC_INS_ADDR_MSB 1
// Device register indices and reset values
`define ASPC_REG_RESULT 2'h0
`define ASPC_REG_COMMAND 2'h1
`define ASPC_REG_OFFSET 2'h2
`define ASPC_REG_GAIN 2'h3
`define ASPC_CMD_SDO_BIT 0
`define ASPC_CMD_RESET 32'h00000000
`define ASPC_CAL_RESET 32'h00000000
// Host APB map
`define ASPC_A_CTRL 8'h00
`define ASPC_A_INSTR 8'h04
`define ASPC_A_WDATA 8'h08
`define ASPC_A_RDATA 8'h0c
`define ASPC_A_STATUS 8'h10
`define ASPC_A_IRQ_STAT 8'h14
`define ASPC_A_IRQ_MASK 8'h18
`define ASPC_A_CLKDIV 8'h1c
`define ASPC_CTRL_GO_BIT 8
`define ASPC_CTRL_RESET 5'h00
`define ASPC_CLKDIV_RESET 8'h30
`endif

/* File: hw/aspc_pkg.sv */
package aspc_pkg;
  typedef enum logic [2:0] {DEV_IDLE, DEV_INSTR, DEV_TURN, DEV_DATA, DEV_DONE} aspc_dev_state_e;
  typedef enum logic [2:0] {H_IDLE, H_INSTR, H_GAP, H_DATA, H_END} aspc_host_state_e;
endpackage

/* File: hw/aspc_if.sv */
`timescale 1ns/1ps
interface aspc_if;
  logic mode;
  logic csN;
  logic sclkDev;
  logic sclkDevOe;
  logic sclkHost;
  logic sclkHostOe;
  logic sdioDev;
  logic sdioDevOe;
  logic sdioHost;
  logic sdioHostOe;
  logic serialDataOut;
  logic serialDataOutOe;
  logic dataReadyLow;
  logic sclkLine;
  logic sdioLine;
  logic sdoLine;
  assign sclkLine = sclkDevOe ? sclkDev : (sclkHostOe ? sclkHost : 1'b0);
  // Pull-down on the data pin keeps an idle instruction harmless
  assign sdioLine = sdioDevOe ? sdioDev : (sdioHostOe ? sdioHost : 1'b0);
  assign sdoLine = serialDataOutOe ? serialDataOut : 1'b1;
  modport device (input mode, csN, sclkLine, sdioLine,
    output sclkDev, sclkDevOe, sdioDev, sdioDevOe, serialDataOut, serialDataOutOe, dataReadyLow);
  modport host (input sclkLine, sdioLine, sdoLine, dataReadyLow,
    output mode, csN, sclkHost, sclkHostOe, sdioHost, sdioHostOe);
endinterface

/* File: hw/aspc_sync.sv */
`timescale 1ns/1ps
module aspc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Signals
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end
  assign syncOut = stage2Reg;
endmodule

/* File: hw/aspc_device.sv */
`timescale 1ns/1ps
`include "aspc_defs.svh"
// Behaviour
// - Slave takes more instructions; ready stays high
// - Master runs one instruction per conversion
// - Refresh result from calibration before ready
// - Ongoing result read blocks refresh
// - Controller finishes twelve clocks before ready
// - Data outputs float except while transmitting
// - Master waits for chip select low
// - Slave answers clocks only with select low
// - Select held low repeats last result read
// - First select high enables continuous read
// - Power-up: bidirectional pin is data output
// - Master, select low: instruction every period
// - All-zero instruction does nothing
// - Default rate 814Hz, period 1.2ms
// - Mode high: device drives half-rate clock
// - Master unread result overwritten each period
// - Mode low: slave, clock at most fifth
// - Slave turnaround two to three clocks
// - Slave without transfer loses old result
module aspc_device #(
  parameter int CONV_CYCLES = `ASPC_CONV_CYCLES,
  parameter int XIN_DIV = `ASPC_XIN_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Serial link
  aspc_if.device link,
  // Converter side
  input wire logic [31:0] rawSample,
  output logic [31:0] resultShown
);
  import aspc_pkg::*;
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int XW = $clog2(XIN_DIV + 1);

  function automatic logic [5:0] dataBits(input logic [7:0] ins);
    dataBits = {1'b0, ins[`ASPC_INS_NB_MSB:`ASPC_INS_NB_LSB], 3'b000} + 6'h08;
  endfunction
  function automatic logic [4:0] shiftAmt(input logic [7:0] ins);
    shiftAmt = {~ins[`ASPC_INS_NB_MSB:`ASPC_INS_NB_LSB], 3'b000};
  endfunction
  function automatic logic readsResult(input logic [7:0] ins);
    readsResult = ins[`ASPC_INS_READ_BIT] && (ins[`ASPC_INS_ADDR_MSB:0] == `ASPC_REG_RESULT);
  endfunction

  logic [3:0] pinS;
  logic modeS;
  logic csLow;
  logic sclkS;
  logic sdioS;
  aspc_sync #(.WIDTH(4)) pinSync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    // Select inverted so the cleared synchroniser reads as deselected after reset
    .asyncIn({link.mode, ~link.csN, link.sclkLine, link.sdioLine}),
    .syncOut(pinS)
  );
  assign modeS = pinS[3];
  assign csLow = pinS[2];
  assign sclkS = pinS[1];
  assign sdioS = pinS[0];

  aspc_dev_state_e stateReg, stateNext;
  logic [CW-1:0] convCntReg, convCntNext;
  logic [XW-1:0] xinCntReg, xinCntNext;
  logic [1:0] turnCntReg, turnCntNext;
  logic sclkPrevReg, sclkPrevNext;
  logic sclkOutReg, sclkOutNext;
  logic sclkOeReg, sclkOeNext;
  logic sdioOutReg, sdioOutNext;
  logic sdioOeReg, sdioOeNext;
  logic sdoReg, sdoNext;
  logic sdoOeReg, sdoOeNext;
  logic drdyReg, drdyNext;
  logic [7:0] instrReg, instrNext;
  logic [31:0] shiftReg, shiftNext;
  logic [5:0] bitCntReg, bitCntNext;
  logic [31:0] regFileReg [4];
  logic [31:0] regFileNext [4];
  logic contEnReg, contEnNext;
  logic contArmedReg, contArmedNext;
  logic doneReg, doneNext;
  logic [31:0] shownReg, shownNext;
  logic xinTick;
  logic convWrap;
  logic mRun;
  logic rise;
  logic fall;
  logic contStart;
  logic [31:0] mask;

  always_comb begin
    stateNext = stateReg;
    convCntNext = convCntReg + CW'(1);
    turnCntNext = turnCntReg;
    sclkPrevNext = sclkS;
    sdioOutNext = sdioOutReg;
    sdioOeNext = sdioOeReg;
    sdoNext = sdoReg;
    sdoOeNext = sdoOeReg;
    drdyNext = drdyReg;
    instrNext = instrReg;
    shiftNext = shiftReg;
    bitCntNext = bitCntReg;
    regFileNext = regFileReg;
    contEnNext = contEnReg;
    contArmedNext = contArmedReg;
    doneNext = doneReg;
    shownNext = regFileReg[`ASPC_REG_RESULT];
    mask = 32'hffffffff >> shiftAmt(instrReg);
    xinTick = xinCntReg == XW'(XIN_DIV - 1);
    xinCntNext = xinTick ? '0 : xinCntReg + XW'(1);
    convWrap = convCntReg == CW'(CONV_CYCLES - 1);
    mRun = modeS && (stateReg == DEV_INSTR || stateReg == DEV_DATA);
    // Device clock runs at half the master clock rate, idling low
    sclkOeNext = modeS;
    sclkOutNext = mRun ? (xinTick ? !sclkOutReg : sclkOutReg) : 1'b0;
    // Slave edges only count while chip select is low; keeps them far apart
    rise = modeS ? (mRun && xinTick && !sclkOutReg) : (csLow && !sclkPrevReg && sclkS);
    fall = modeS ? (mRun && xinTick && sclkOutReg) : (csLow && sclkPrevReg && !sclkS);
    contStart = convWrap && contEnReg && contArmedReg && csLow;
    if (convWrap) begin
      convCntNext = '0;
    end
    if (!csLow) begin
      contEnNext = 1'b1;
      contArmedNext = 1'b0;
    end
    case (stateReg)
      DEV_IDLE: begin
        bitCntNext = '0;
        if (contStart) begin
          stateNext = DEV_TURN;
        end else if (modeS && !drdyReg && !doneReg && csLow) begin
          stateNext = DEV_INSTR;
        end else if (!modeS && csLow) begin
          stateNext = DEV_INSTR;
        end
      end
      DEV_INSTR: begin
        if (contStart && bitCntReg == 6'h00) begin
          stateNext = DEV_TURN;
        end else if (rise) begin
          instrNext = {instrReg[6:0], sdioS};
          bitCntNext = bitCntReg + 6'h01;
        end else if (fall && bitCntReg == 6'h08) begin
          stateNext = DEV_TURN;
          bitCntNext = '0;
        end
      end
      DEV_TURN: begin
        // Pause lets the controller release the shared data pin first
        if (xinTick) begin
          turnCntNext = turnCntReg + 2'h1;
          if (turnCntReg == 2'(`ASPC_TURN_XIN - 1)) begin
            stateNext = DEV_DATA;
            turnCntNext = '0;
            shiftNext = '0;
            if (instrReg[`ASPC_INS_READ_BIT]) begin
              shiftNext = regFileReg[instrReg[`ASPC_INS_ADDR_MSB:0]] << shiftAmt(instrReg);
              if (regFileReg[`ASPC_REG_COMMAND][`ASPC_CMD_SDO_BIT]) begin
                sdoOeNext = 1'b1;
                sdoNext = shiftNext[31];
              end else begin
                sdioOeNext = 1'b1;
                sdioOutNext = shiftNext[31];
              end
            end
          end
        end
      end
      DEV_DATA: begin
        if (rise) begin
          bitCntNext = bitCntReg + 6'h01;
          if (!instrReg[`ASPC_INS_READ_BIT]) begin
            shiftNext = {shiftReg[30:0], sdioS};
          end
        end else if (fall) begin
          if (bitCntReg == dataBits(instrReg)) begin
            stateNext = DEV_DONE;
            if (!instrReg[`ASPC_INS_READ_BIT]
                && instrReg[`ASPC_INS_ADDR_MSB:0] != `ASPC_REG_RESULT) begin
              regFileNext[instrReg[`ASPC_INS_ADDR_MSB:0]] =
                (regFileReg[instrReg[`ASPC_INS_ADDR_MSB:0]] & ~mask) | (shiftReg & mask);
            end
          end else if (instrReg[`ASPC_INS_READ_BIT]) begin
            shiftNext = {shiftReg[30:0], 1'b0};
            sdioOutNext = sdioOeReg & shiftReg[30];
            sdoNext = sdoOeReg & shiftReg[30];
          end
        end
      end
      DEV_DONE: begin
        // Chip select never releases a driving output mid-transfer
        sdioOeNext = 1'b0;
        sdioOutNext = 1'b0;
        sdoOeNext = 1'b0;
        sdoNext = 1'b0;
        drdyNext = 1'b1;
        doneNext = modeS;
        contArmedNext = readsResult(instrReg) && csLow;
        stateNext = DEV_IDLE;
      end
      default: begin
        stateNext = DEV_IDLE;
      end
    endcase
    if (convCntReg == CW'(CONV_CYCLES - 3)) begin
      drdyNext = 1'b1;
    end
    if (convCntReg == CW'(CONV_CYCLES - 2)) begin
      // Simplified calibration; writes landing here may corrupt the result
      if (!((stateReg == DEV_TURN || stateReg == DEV_DATA) && readsResult(instrReg))) begin
        regFileNext[`ASPC_REG_RESULT] = rawSample - regFileReg[`ASPC_REG_OFFSET]
          + regFileReg[`ASPC_REG_GAIN];
      end
    end
    if (convWrap) begin
      drdyNext = 1'b0;
      doneNext = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateReg <= DEV_IDLE;
      convCntReg <= '0;
      xinCntReg <= '0;
      turnCntReg <= '0;
      sclkPrevReg <= 1'b0;
      sclkOutReg <= 1'b0;
      sclkOeReg <= 1'b0;
      sdioOutReg <= 1'b0;
      sdioOeReg <= 1'b0;
      sdoReg <= 1'b0;
      sdoOeReg <= 1'b0;
      drdyReg <= 1'b1;
      instrReg <= 8'h00;
      shiftReg <= 32'h00000000;
      bitCntReg <= '0;
      regFileReg[`ASPC_REG_RESULT] <= 32'h00000000;
      regFileReg[`ASPC_REG_COMMAND] <= `ASPC_CMD_RESET;
      regFileReg[`ASPC_REG_OFFSET] <= `ASPC_CAL_RESET;
      regFileReg[`ASPC_REG_GAIN] <= `ASPC_CAL_RESET;
      contEnReg <= 1'b0;
      contArmedReg <= 1'b0;
      doneReg <= 1'b0;
      shownReg <= 32'h00000000;
    end else begin
      stateReg <= stateNext;
      convCntReg <= convCntNext;
      xinCntReg <= xinCntNext;
      turnCntReg <= turnCntNext;
      sclkPrevReg <= sclkPrevNext;
      sclkOutReg <= sclkOutNext;
      sclkOeReg <= sclkOeNext;
      sdioOutReg <= sdioOutNext;
      sdioOeReg <= sdioOeNext;
      sdoReg <= sdoNext;
      sdoOeReg <= sdoOeNext;
      drdyReg <= drdyNext;
      instrReg <= instrNext;
      shiftReg <= shiftNext;
      bitCntReg <= bitCntNext;
      regFileReg <= regFileNext;
      contEnReg <= contEnNext;
      contArmedReg <= contArmedNext;
      doneReg <= doneNext;
      shownReg <= shownNext;
    end
  end

  assign link.sclkDev = sclkOutReg;
  assign link.sclkDevOe = sclkOeReg;
  assign link.sdioDev = sdioOutReg;
  assign link.sdioDevOe = sdioOeReg;
  assign link.serialDataOut = sdoReg;
  assign link.serialDataOutOe = sdoOeReg;
  assign link.dataReadyLow = drdyReg;
  assign resultShown = shownReg;
endmodule

/* File: hw/aspc_host.sv */
`timescale 1ns/1ps
`include "aspc_defs.svh"
module aspc_host #(
  parameter int CONV_CYCLES = `ASPC_CONV_CYCLES,
  parameter int XIN_DIV = `ASPC_XIN_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Serial link
  aspc_if.host link
);
  import aspc_pkg::*;
  localparam logic [7:0] MIN_DIV = 8'(`ASPC_SLAVE_SCLK_RATIO * XIN_DIV);
  localparam logic [7:0] GAP_CYC = 8'(`ASPC_HOST_GAP_XIN * XIN_DIV);
  localparam logic [31:0] LATEST = 32'(CONV_CYCLES - `ASPC_GUARD_XIN * XIN_DIV);

  logic [3:0] pinS;
  aspc_sync #(.WIDTH(4)) pinSync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .asyncIn({link.sclkLine, link.sdioLine, link.sdoLine, link.dataReadyLow}),
    .syncOut(pinS)
  );

  aspc_host_state_e stReg, stNext;
  logic [4:0] ctrlReg, ctrlNext;
  logic [7:0] instrReg, instrNext;
  logic [31:0] wdataReg, wdataNext, rdataReg, rdataNext;
  logic [2:0] irqStatReg, irqStatNext, irqMaskReg, irqMaskNext;
  logic [7:0] divReg, divNext, halfCntReg, halfCntNext, gapCntReg, gapCntNext;
  logic [31:0] prdataReg, prdataNext, shiftReg, shiftNext, sinceReg, sinceNext;
  logic preadyReg, preadyNext, pslverrReg, pslverrNext, irqReg, irqNext;
  logic csNReg, csNNext, sclkReg, sclkNext, sdioReg, sdioNext, sdioOeReg, sdioOeNext;
  logic prevSclkReg, prevDrdyReg;
  logic [5:0] bitCntReg, bitCntNext;
  logic [5:0] total;
  logic [7:0] effDiv;
  logic own, run, halfEnd, hRise, hFall, wr, go, isRead;
  logic [2:0] ev;
  logic [31:0] est;

  always_comb begin
    stNext = stReg;
    ctrlNext = ctrlReg;
    instrNext = instrReg;
    wdataNext = wdataReg;
    rdataNext = rdataReg;
    irqMaskNext = irqMaskReg;
    divNext = divReg;
    halfCntNext = halfCntReg;
    gapCntNext = '0;
    shiftNext = shiftReg;
    csNNext = csNReg;
    sclkNext = sclkReg;
    sdioNext = sdioReg;
    sdioOeNext = sdioOeReg;
    bitCntNext = bitCntReg;
    ev = 3'h0;
    isRead = instrReg[`ASPC_INS_READ_BIT];
    total = {1'b0, instrReg[`ASPC_INS_NB_MSB:`ASPC_INS_NB_LSB], 3'b000} + 6'h08;
    effDiv = (divReg < MIN_DIV) ? MIN_DIV : divReg;
    est = 32'(total + 6'h08) * 32'(effDiv) + 32'(GAP_CYC) + sinceReg;
    own = !ctrlReg[0];
    run = stReg == H_INSTR || stReg == H_DATA;
    halfEnd = halfCntReg == (effDiv >> 1) - 8'h01;
    hRise = own ? (run && halfEnd && !sclkReg) : (run && !prevSclkReg && pinS[3]);
    hFall = own ? (run && halfEnd && sclkReg) : (run && prevSclkReg && !pinS[3]);
    if (own && run) begin
      halfCntNext = halfEnd ? 8'h00 : halfCntReg + 8'h01;
      sclkNext = halfEnd ? !sclkReg : sclkReg;
    end
    sinceNext = (prevDrdyReg && !pinS[0]) ? 32'h0 : sinceReg + {31'h0, ~&sinceReg};
    ev[1] = prevDrdyReg && !pinS[0];
    // APB: one wait-free access phase, answer registered from setup
    wr = psel && penable && pwrite && preadyReg;
    go = wr && paddr == `ASPC_A_CTRL && pwdata[`ASPC_CTRL_GO_BIT];
    preadyNext = psel && !penable;
    pslverrNext = psel && !penable && (paddr[1:0] != 2'h0 || paddr > `ASPC_A_CLKDIV);
    case (paddr)
      `ASPC_A_CTRL: prdataNext = {27'h0, ctrlReg};
      `ASPC_A_INSTR: prdataNext = {24'h0, instrReg};
      `ASPC_A_WDATA: prdataNext = wdataReg;
      `ASPC_A_RDATA: prdataNext = rdataReg;
      `ASPC_A_STATUS: prdataNext = {30'h0, pinS[0], stReg != H_IDLE};
      `ASPC_A_IRQ_STAT: prdataNext = {29'h0, irqStatReg};
      `ASPC_A_IRQ_MASK: prdataNext = {29'h0, irqMaskReg};
      `ASPC_A_CLKDIV: prdataNext = {24'h0, divReg};
      default: prdataNext = 32'h0;
    endcase
    if (!(psel && !penable)) begin
      prdataNext = 32'h0;
    end
    if (wr && stReg == H_IDLE) begin
      case (paddr)
        `ASPC_A_CTRL: ctrlNext = pwdata[4:0];
        `ASPC_A_INSTR: instrNext = pwdata[7:0];
        `ASPC_A_WDATA: wdataNext = pwdata;
        `ASPC_A_CLKDIV: divNext = pwdata[7:0];
        default: ;
      endcase
    end
    if (wr && paddr == `ASPC_A_IRQ_MASK) begin
      irqMaskNext = pwdata[2:0];
    end
    case (stReg)
      H_IDLE: begin
        sclkNext = 1'b0;
        halfCntNext = 8'h00;
        bitCntNext = '0;
        if (go) begin
          if (pwdata[2] && own && est > LATEST) begin
            ev[2] = 1'b1;
          end else begin
            csNNext = 1'b0;
            if (pwdata[4]) begin
              stNext = H_DATA;
              shiftNext = 32'h0;
            end else begin
              stNext = H_INSTR;
              shiftNext = {instrReg, 24'h0};
              sdioOeNext = 1'b1;
              sdioNext = instrReg[7];
            end
          end
        end
      end
      H_INSTR: begin
        if (hRise) begin
          bitCntNext = bitCntReg + 6'h01;
        end else if (hFall) begin
          if (bitCntReg == 6'h08) begin
            stNext = own ? H_GAP : H_DATA;
            bitCntNext = '0;
            shiftNext = isRead ? 32'h0 : wdataReg << {~instrReg[6:5], 3'b000};
            sdioOeNext = !isRead;
            sdioNext = !isRead && shiftNext[31];
          end else begin
            shiftNext = {shiftReg[30:0], 1'b0};
            sdioNext = shiftReg[30];
          end
        end
      end
      H_GAP: begin
        // Waits out the device turnaround before clocking data
        gapCntNext = gapCntReg + 8'h01;
        if (gapCntReg == GAP_CYC) begin
          stNext = H_DATA;
        end
      end
      H_DATA: begin
        if (hRise) begin
          bitCntNext = bitCntReg + 6'h01;
          if (isRead || ctrlReg[4]) begin
            shiftNext = {shiftReg[30:0], ctrlReg[3] ? pinS[1] : pinS[2]};
          end
        end else if (hFall) begin
          if (bitCntReg == total) begin
            stNext = H_END;
          end else if (!isRead && !ctrlReg[4]) begin
            shiftNext = {shiftReg[30:0], 1'b0};
            sdioNext = shiftReg[30];
          end
        end
      end
      H_END: begin
        rdataNext = shiftReg;
        csNNext = !ctrlReg[1];
        sdioOeNext = 1'b0;
        sdioNext = 1'b0;
        ev[0] = 1'b1;
        stNext = H_IDLE;
      end
      default: begin
        stNext = H_IDLE;
      end
    endcase
    // New events win over a same-cycle clear
    irqStatNext = (irqStatReg & ~((wr && paddr == `ASPC_A_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | ev;
    irqNext = |(irqStatReg & irqMaskReg);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stReg <= H_IDLE;
      ctrlReg <= `ASPC_CTRL_RESET;
      instrReg <= 8'h00;
      wdataReg <= 32'h0;
      rdataReg <= 32'h0;
      irqStatReg <= 3'h0;
      irqMaskReg <= 3'h0;
      divReg <= `ASPC_CLKDIV_RESET;
      halfCntReg <= 8'h00;
      gapCntReg <= 8'h00;
      prdataReg <= 32'h0;
      shiftReg <= 32'h0;
      sinceReg <= 32'h0;
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
      irqReg <= 1'b0;
      csNReg <= 1'b1;
      sclkReg <= 1'b0;
      sdioReg <= 1'b0;
      sdioOeReg <= 1'b0;
      prevSclkReg <= 1'b0;
      prevDrdyReg <= 1'b0;
      bitCntReg <= '0;
    end else begin
      stReg <= stNext;
      ctrlReg <= ctrlNext;
      instrReg <= instrNext;
      wdataReg <= wdataNext;
      rdataReg <= rdataNext;
      irqStatReg <= irqStatNext;
      irqMaskReg <= irqMaskNext;
      divReg <= divNext;
      halfCntReg <= halfCntNext;
      gapCntReg <= gapCntNext;
      prdataReg <= prdataNext;
      shiftReg <= shiftNext;
      sinceReg <= sinceNext;
      preadyReg <= preadyNext;
      pslverrReg <= pslverrNext;
      irqReg <= irqNext;
      csNReg <= csNNext;
      sclkReg <= sclkNext;
      sdioReg <= sdioNext;
      sdioOeReg <= sdioOeNext;
      prevSclkReg <= pinS[3];
      prevDrdyReg <= pinS[0];
      bitCntReg <= bitCntNext;
    end
  end

  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = pslverrReg;
  assign irq = irqReg;
  assign link.mode = ctrlReg[0];
  assign link.csN = csNReg;
  assign link.sclkHost = sclkReg;
  assign link.sclkHostOe = !ctrlReg[0];
  assign link.sdioHost = sdioReg;
  assign link.sdioHostOe = sdioOeReg;
endmodule

/* File: sim/aspc_sva.sv */
`timescale 1ns/1ps
module aspc_sva #(parameter int CONV_CYCLES = 6000) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link
  input wire logic mode,
  input wire logic csN,
  input wire logic sclkDev,
  input wire logic sclkDevOe,
  input wire logic sdioDevOe,
  input wire logic serialDataOutOe,
  input wire logic dataReadyLow,
  input wire logic sclkLine
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Ages since the last clock fall and ready fall
  int lowCnt, gapCnt, riseCnt;
  logic seen;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt <= 0;
      gapCnt <= 0;
      riseCnt <= 0;
      seen <= 1'b0;
    end else begin
      lowCnt <= $fell(sclkLine) ? 0 : lowCnt + 1;
      gapCnt <= $fell(dataReadyLow) ? 0 : gapCnt + 1;
      riseCnt <= $fell(dataReadyLow) ? 0 : riseCnt + int'(mode && $rose(sclkDev));
      seen <= seen | $fell(dataReadyLow);
    end
  end
  property p_clk_dir; mode[*6] |-> sclkDevOe; endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock not driven");
  property p_half; sclkDevOe && $changed(sclkDev) |=> $stable(sclkDev)[*7]; endproperty
  a_half: assert property (p_half) else $error("clock rate wrong");
  property p_one_out; !(sdioDevOe && serialDataOutOe); endproperty
  a_one_out: assert property (p_one_out) else $error("both outputs on");
  // Continuous read starts without an instruction, so only fresh falls count
  property p_turn; !mode && $rose(sdioDevOe) && lowCnt < 100
    |-> lowCnt inside {[18:36]}; endproperty
  a_turn: assert property (p_turn) else $error("turnaround time");
  property p_pulse; $fell(dataReadyLow) |-> $past(dataReadyLow, 2); endproperty
  a_pulse: assert property (p_pulse) else $error("no ready pulse");
  property p_period; seen && $fell(dataReadyLow) |-> gapCnt == CONV_CYCLES - 1; endproperty
  a_period: assert property (p_period) else $error("period wrong");
  property p_one_instr; riseCnt <= 40; endproperty
  a_one_instr: assert property (p_one_instr) else $error("extra transfer");
  property p_go; (mode && !csN)[*8] ##0 $fell(dataReadyLow)
    |-> ##[1:120] $rose(sclkDev); endproperty
  a_go: assert property (p_go) else $error("master idle");
  c_slave: cover property (!mode && $rose(sdioDevOe));
  c_master: cover property (mode && $rose(sdioDevOe));
  c_held: cover property (mode && csN && $fell(dataReadyLow));
endmodule

/* File: sim/adc_serial_port_control_tb_top.sv */
`timescale 1ns/1ps
`include "aspc_defs.svh"
module adc_serial_port_control_tb_top;
  localparam int CONV = 6000;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, raw = 32'h0;
  logic [31:0] prdata, shown, rd, old, off, gain;
  logic pready, pslverr, irq, err, hold = 1'b0;
  int error_cnt = 0, compares = 0, rises = 0, snap;
  aspc_if lnk();
  aspc_device #(.CONV_CYCLES(CONV)) i_aspc_device (.sys_clk, .sys_rst, .link(lnk),
    .rawSample(raw), .resultShown(shown));
  aspc_host #(.CONV_CYCLES(CONV)) i_aspc_host (.sys_clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .link(lnk));
  aspc_sva #(.CONV_CYCLES(CONV)) i_aspc_sva (.sys_clk, .sys_rst, .mode(lnk.mode),
    .csN(lnk.csN), .sclkDev(lnk.sclkDev), .sclkDevOe(lnk.sclkDevOe),
    .sdioDevOe(lnk.sdioDevOe), .serialDataOutOe(lnk.serialDataOutOe),
    .dataReadyLow(lnk.dataReadyLow), .sclkLine(lnk.sclkLine));
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge lnk.sclkLine) rises++;
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Busy is polled; the host decides how long a frame takes
  task automatic xfer(input logic m, input logic [7:0] ins, input logic [31:0] wd);
    apb(1'b1, `ASPC_A_INSTR, 32'(ins));
    apb(1'b1, `ASPC_A_WDATA, wd);
    apb(1'b1, `ASPC_A_CTRL, {23'h0, 1'b1, 6'h0, hold, m});
    apb(1'b0, `ASPC_A_STATUS, 32'h0);
    while (rd[0] !== 1'b0) apb(1'b0, `ASPC_A_STATUS, 32'h0);
    apb(1'b0, `ASPC_A_RDATA, 32'h0);
  endtask
  task automatic fall(input int n);
    repeat (n) @(negedge lnk.dataReadyLow);
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] calc();
    return raw - off + gain;
  endfunction
  initial begin
    void'($urandom(35097));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b1, `ASPC_A_CLKDIV, 32'h28);
    apb(1'b1, `ASPC_A_IRQ_MASK, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    raw <= $urandom;
    fall(2);
    xfer(1'b0, 8'h00, $urandom);
    xfer(1'b0, 8'he0, 32'h0);
    chk("slave rd", raw, rd);
    chk("ready", 32'h1, 32'(lnk.dataReadyLow));
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, `ASPC_A_IRQ_STAT, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq clr", 32'h0, 32'(irq));
    $display("test slave done");
    old = raw;
    fall(1);
    raw <= $urandom;
    // Start late so the data phase spans the refresh
    repeat (CONV - 900) @(posedge sys_clk);
    // Guarded start this late cannot finish before the next ready
    apb(1'b1, `ASPC_A_CTRL, 32'h104);
    apb(1'b0, `ASPC_A_IRQ_STAT, 32'h0);
    chk("refused", 32'h4, rd & 32'h4);
    xfer(1'b0, 8'he0, 32'h0);
    chk("blocked", old, rd);
    chk("kept", old, shown);
    $display("test block done");
    fall(1);
    off = $urandom;
    gain = $urandom;
    xfer(1'b0, 8'h62, off);
    xfer(1'b0, 8'h63, gain);
    raw <= $urandom;
    fall(2);
    xfer(1'b0, 8'he0, 32'h0);
    chk("cal", calc(), rd);
    $display("test cal done");
    apb(1'b1, `ASPC_A_CTRL, 32'h1);
    raw <= $urandom;
    fall(1);
    snap = rises;
    fall(1);
    chk("held", snap, rises);
    // Select stays low after this read, so the next ready repeats it
    hold = 1'b1;
    xfer(1'b1, 8'he0, 32'h0);
    chk("master rd", calc(), rd);
    $display("test master done");
    snap = rises;
    fall(1);
    repeat (1000) @(posedge sys_clk);
    chk("cont", snap + 32, rises);
    $display("test cont done");
    tally_and_finish();
  end
endmodule
